// ===== verilog/ramp_pkg.sv
// constants, types and register map of the motor voltage ramp controller
package ramp_pkg;
  // ****************************************
  // timing
  // ****************************************
  localparam int unsigned CLK_HZ = 125_000_000;
  localparam int unsigned DS_MS = 100; // ramp settings count in tenths of a second
  localparam int unsigned CYC_PER_DS = CLK_HZ / 1000 * DS_MS;
  localparam int unsigned CFG_WIN_MS = 2000;
  localparam int unsigned CFG_WIN_CYC = CLK_HZ / 1000 * CFG_WIN_MS;
  localparam int unsigned FLASH_MS = 1000;
  localparam int unsigned FLASH_CYC = CLK_HZ / 1000 * FLASH_MS;
  localparam int unsigned FLASH_HZ = 8;
  localparam int unsigned FLASH_HALF_CYC = CLK_HZ / (2 * FLASH_HZ);
  // ****************************************
  // voltage and time scales
  // ****************************************
  localparam int VW = 14;
  localparam int TW = 9;
  localparam logic [13:0] V_FULL = 14'h3fff; // 100 % of mains_line_voltage
  localparam logic [13:0] V_MIN = 14'h1333; // 30 %
  localparam logic [8:0] T_RISE_MIN = 9'h00a; // 1 s
  localparam logic [8:0] T_MAX = 9'h12c; // 30 s
  localparam logic [13:0] RST_USTART = 14'h1333; // raw 4915
  localparam logic [8:0] RST_TRISE = 9'h032; // raw 50
  localparam logic [8:0] RST_TFALL = 9'h000;
  // parameter_number of each fieldbus setting
  localparam int PARAMETER_NUMBER_USTART = 11;
  localparam int PARAMETER_NUMBER_TRISE = 111;
  localparam int PARAMETER_NUMBER_TFALL = 114;
  // ****************************************
  // register map
  // ****************************************
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_CMD = 8'h04;
  localparam logic [7:0] A_PAR_USTART = 8'h08;
  localparam logic [7:0] A_PAR_TRISE = 8'h0c;
  localparam logic [7:0] A_PAR_TFALL = 8'h10;
  localparam logic [7:0] A_STATUS = 8'h14;
  localparam logic [7:0] A_SETPOINT = 8'h18;
  localparam logic [7:0] A_IRQ_STAT = 8'h1c;
  localparam logic [7:0] A_IRQ_CLR = 8'h20;
  localparam logic [7:0] A_IRQ_EN = 8'h24;
  localparam int IRQ_W = 3;
  localparam int IRQ_UP = 0; // rise done
  localparam int IRQ_OFF = 1; // output switched off
  localparam int IRQ_CFG = 2; // configuration failed
  // ****************************************
  // types
  // ****************************************
  typedef enum logic [1:0] {ST_OFF, ST_RISE, ST_FULL, ST_FALL} ramp_state_t;
  typedef struct packed {
    logic [13:0] ustart;
    logic [8:0] trise;
    logic [8:0] tfall;
  } ramp_set_t;
endpackage : ramp_pkg

// ===== verilog/ramp_stepper.sv
// timebase that paces ramp steps so a full span takes the selected time
module ramp_stepper (
  input wire logic clock, // system clock
  input wire logic resetn, // sync reset, active low
  input wire logic active, // a ramp is running
  input wire logic restart, // clear phase at ramp start
  input wire logic [13:0] span, // lsb steps in a full ramp
  input wire logic [31:0] total, // clock cycles of a full ramp
  output logic step // one lsb step due
);
  typedef struct packed {
    logic [31:0] err;
    logic step;
  } stp_t;
  stp_t q, n;
  logic [32:0] sum;
  // ****************************************
  // error accumulator: one step per total/span cycles
  // ****************************************
  always_comb begin
    n = q;
    n.step = 1'b0;
    sum = {1'b0, q.err} + {19'h0, span};
    if (!active || restart) begin
      n.err = 32'h0;
    end else if (sum >= {1'b0, total}) begin
      n.err = 32'(sum - {1'b0, total}); // see [RQ17]
      n.step = 1'b1;
    end else begin
      n.err = sum[31:0];
    end
  end
  always_ff @(posedge clock) begin
    if (!resetn) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end
  assign step = q.step;
endmodule : ramp_stepper

// ===== verilog/config_watch.sv
// power-up configuration window watcher with failure flash
module config_watch #(
  parameter int unsigned WIN_CYC = ramp_pkg::CFG_WIN_CYC,
  parameter int unsigned FL_CYC = ramp_pkg::FLASH_CYC,
  parameter int unsigned HALF_CYC = ramp_pkg::FLASH_HALF_CYC
) (
  input wire logic clock, // system clock
  input wire logic resetn, // sync reset, active low
  input wire logic u_max, // start voltage knob at max
  input wire logic u_min, // start voltage knob at min
  input wire logic t_max, // rise time knob at max
  input wire logic t_min, // rise time knob at min
  output logic fail, // one-cycle failure event
  output logic flash // both indicators lit
);
  typedef enum {CW_ARM, CW_WIN, CW_FLASH, CW_DONE} cw_state_t;
  typedef struct packed {
    cw_state_t st;
    logic [31:0] cnt;
    logic [31:0] half;
    logic [1:0] su;
    logic [1:0] stt;
    logic fail;
    logic led;
  } cw_t;
  cw_t q, n;
  logic bad;
  // move sequence per knob: 0 at max, 1 left max, 2 reached min, 3 back at max
  function automatic logic [1:0] seq(input logic [1:0] s, input logic mx, input logic mn);
    logic [1:0] r;
    r = s;
    if (s == 2'h0 && !mx) r = 2'h1;
    else if (s == 2'h1 && mn) r = 2'h2;
    else if (s == 2'h2 && mx) r = 2'h3;
    return r;
  endfunction : seq
  always_comb begin
    n = q;
    n.fail = 1'b0;
    n.cnt = q.cnt + 32'h1;
    bad = 1'b0;
    unique case (q.st)
      CW_ARM: begin
        n.cnt = 32'h0;
        n.st = (u_max && t_max) ? CW_WIN : CW_DONE;
      end
      CW_WIN: begin
        n.su = seq(q.su, u_max, u_min);
        n.stt = seq(q.stt, t_max, t_min);
        bad = (n.su == 2'h1 || n.su == 2'h2) && (n.stt == 2'h1 || n.stt == 2'h2); // see [RQ14]
        if (q.cnt >= WIN_CYC - 1) begin
          bad = bad || n.su[0] ^ n.su[1] || n.stt[0] ^ n.stt[1]; // see [RQ13]
          n.st = CW_DONE;
        end
        if (bad) begin
          n.st = CW_FLASH;
          n.fail = 1'b1;
          n.cnt = 32'h0;
          n.half = 32'h0;
          n.led = 1'b1;
        end
      end
      CW_FLASH: begin
        n.half = q.half + 32'h1;
        if (q.half >= HALF_CYC - 1) begin
          n.half = 32'h0;
          n.led = !q.led; // see [RQ12]
        end
        if (q.cnt >= FL_CYC - 1) begin
          n.st = CW_DONE;
          n.led = 1'b0;
        end
      end
      CW_DONE: begin
        n.cnt = q.cnt;
      end
    endcase
  end
  always_ff @(posedge clock) begin
    if (!resetn) begin
      q <= '{st: CW_ARM, default: '0};
    end else begin
      q <= n;
    end
  end
  assign fail = q.fail;
  assign flash = q.led;
  a_cfg_flash_on: assert property (@(posedge clock) disable iff (!resetn)
    q.fail |-> q.led && q.st == CW_FLASH) else $error("no flash after config fail"); // see [RQ12]
endmodule : config_watch

// ===== verilog/motor_voltage_ramp_control.sv
// soft start voltage ramp controller with register port and interrupt
// Operation
// [RQ1] start voltage 30-100 %, default 30 %
// [RQ2] linear rise to 100 % in 1-30 s
// [RQ3] linear fall to start level in 0-30 s
// [RQ4] run command falling edge starts fall
// [RQ5] at start level, output switches off
// [RQ6] zero fall time switches off at once
// [RQ7] large units: enable low cuts output
// [RQ8] run during fall restarts rise from present
// [RQ9] partner keeps enable steady without fieldbus
// [RQ10] fieldbus stop, ramped or immediate
// [RQ11] fieldbus parameters replace knob settings
// [RQ12] failed configuration flashes both indicators 1 s
// [RQ13] configuration not finished in 2 s fails
// [RQ14] simultaneous voltage and time moves fail
// [RQ15] run command rising edge starts rise
// [RQ16] partner raises enable before run
// [RQ17] setpoint stepped by fixed timebase, exact time
// [RQ18] hold 100 % until stopped
module motor_voltage_ramp_control #(
  parameter bit LARGE_UNIT = 1'b1, // unit rated 41 A and above
  parameter bit FIELDBUS = 1'b1, // unit has the fieldbus
  parameter int unsigned CYC_DS = ramp_pkg::CYC_PER_DS,
  parameter int unsigned WIN_CYC = ramp_pkg::CFG_WIN_CYC,
  parameter int unsigned FL_CYC = ramp_pkg::FLASH_CYC,
  parameter int unsigned HALF_CYC = ramp_pkg::FLASH_HALF_CYC
) (
  input wire logic clock, // system clock, 125 MHz
  input wire logic resetn, // sync reset, active low
  input wire logic run_command_input, // run pin, async
  input wire logic enable_in, // enable pin, async
  input wire logic [13:0] pot_ustart, // start voltage knob
  input wire logic [8:0] pot_trise, // rise time knob, 0.1 s
  input wire logic [8:0] pot_tfall, // fall time knob, 0.1 s
  input wire logic [7:0] addr, // register byte address
  input wire logic [31:0] wdata, // write data
  input wire logic wr, // write strobe
  input wire logic rd, // read strobe
  output logic [31:0] rdata, // read data, cycle after rd
  output logic [13:0] voltage_setpoint, // output voltage, full scale 100 %
  output logic output_on, // power stage enabled
  output logic irq, // interrupt, level
  output logic led_green, // green indicator
  output logic led_red // red indicator
);
  typedef struct packed {
    logic [1:0] run_m;
    logic run_p;
    logic [1:0] en_m;
    ramp_pkg::ramp_state_t st;
    logic [13:0] sp;
    logic on;
    logic use_fb;
    ramp_pkg::ramp_set_t par;
    logic [2:0] irq_st;
    logic [2:0] irq_en;
    logic irq;
    logic [31:0] rdata;
    logic led;
  } ctl_t;
  ctl_t q, n;
  ramp_pkg::ramp_set_t cur;
  logic run_s, en_s, run_rise, run_fall, cut, stop_ramp, stop_now;
  logic step, cfg_fail, flash;
  logic [2:0] ev, clr;
  logic [13:0] span;
  logic [31:0] total;
  // ****************************************
  // setting selection and clamping
  // ****************************************
  always_comb begin
    cur = (FIELDBUS && q.use_fb) ? q.par : '{pot_ustart, pot_trise, pot_tfall}; // see [RQ11]
    if (cur.ustart < ramp_pkg::V_MIN) cur.ustart = ramp_pkg::V_MIN; // see [RQ1]
    if (cur.trise < ramp_pkg::T_RISE_MIN) cur.trise = ramp_pkg::T_RISE_MIN; // see [RQ2]
    if (cur.trise > ramp_pkg::T_MAX) cur.trise = ramp_pkg::T_MAX;
    if (cur.tfall > ramp_pkg::T_MAX) cur.tfall = ramp_pkg::T_MAX; // see [RQ3]
  end
  assign run_s = q.run_m[1];
  assign en_s = q.en_m[1];
  assign run_rise = run_s && !q.run_p;
  assign run_fall = !run_s && q.run_p;
  assign stop_ramp = FIELDBUS && wr && addr == ramp_pkg::A_CMD && wdata[0];
  assign stop_now = FIELDBUS && wr && addr == ramp_pkg::A_CMD && wdata[1];
  // enable is only honoured on large units; partner holds it steady otherwise
  assign cut = (LARGE_UNIT && !en_s) || stop_now; // see [RQ7] [RQ9]
  assign clr = (wr && addr == ramp_pkg::A_IRQ_CLR) ? wdata[2:0] : 3'h0;
  assign span = ramp_pkg::V_FULL - cur.ustart;
  assign total = 32'(32'(q.st == ramp_pkg::ST_FALL ? cur.tfall : cur.trise) * CYC_DS);
  // ****************************************
  // ramp timebase and configuration watcher
  // ****************************************
  ramp_stepper u_stepper (
    .clock(clock),
    .resetn(resetn),
    .active(q.st == ramp_pkg::ST_RISE || q.st == ramp_pkg::ST_FALL),
    .restart(n.st != q.st),
    .span(span),
    .total(total),
    .step(step)
  );
  config_watch #(
    .WIN_CYC(WIN_CYC),
    .FL_CYC(FL_CYC),
    .HALF_CYC(HALF_CYC)
  ) u_cfg (
    .clock(clock),
    .resetn(resetn),
    .u_max(pot_ustart >= ramp_pkg::V_FULL),
    .u_min(pot_ustart <= ramp_pkg::V_MIN),
    .t_max(pot_trise >= ramp_pkg::T_MAX),
    .t_min(pot_trise <= ramp_pkg::T_RISE_MIN),
    .fail(cfg_fail),
    .flash(flash)
  );
  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    n = q;
    ev = 3'h0;
    n.run_m = {q.run_m[0], run_command_input};
    n.run_p = run_s;
    n.en_m = {q.en_m[0], enable_in};
    n.led = flash;
    if (wr) begin
      unique case (addr)
        ramp_pkg::A_CTRL: n.use_fb = wdata[0];
        ramp_pkg::A_PAR_USTART: n.par.ustart = wdata[13:0];
        ramp_pkg::A_PAR_TRISE: n.par.trise = wdata[8:0];
        ramp_pkg::A_PAR_TFALL: n.par.tfall = wdata[8:0];
        ramp_pkg::A_IRQ_EN: n.irq_en = wdata[2:0];
        default: ;
      endcase
    end
    unique case (q.st)
      ramp_pkg::ST_OFF: begin
        if (run_rise && !cut) begin
          n.st = ramp_pkg::ST_RISE; // see [RQ15] [RQ16]
          n.sp = cur.ustart; // see [RQ1]
          n.on = 1'b1;
        end
      end
      ramp_pkg::ST_RISE: begin
        if (cut || ((run_fall || stop_ramp) && cur.tfall == 9'h0)) begin
          n.st = ramp_pkg::ST_OFF; // see [RQ6] [RQ7] [RQ10]
        end else if (run_fall || stop_ramp) begin
          n.st = ramp_pkg::ST_FALL; // see [RQ4] [RQ10]
        end else if (q.sp >= ramp_pkg::V_FULL) begin
          n.st = ramp_pkg::ST_FULL;
          ev[ramp_pkg::IRQ_UP] = 1'b1;
        end else if (step) begin
          n.sp = q.sp + 14'h1; // see [RQ2] [RQ17]
        end
      end
      ramp_pkg::ST_FULL: begin
        if (cut || ((run_fall || stop_ramp) && cur.tfall == 9'h0)) begin
          n.st = ramp_pkg::ST_OFF; // see [RQ6]
        end else if (run_fall || stop_ramp) begin
          n.st = ramp_pkg::ST_FALL; // see [RQ4]
        end else begin
          n.sp = ramp_pkg::V_FULL; // see [RQ18]
        end
      end
      ramp_pkg::ST_FALL: begin
        if (cut) begin
          n.st = ramp_pkg::ST_OFF;
        end else if (run_rise && !stop_ramp) begin
          n.st = ramp_pkg::ST_RISE; // see [RQ8]
        end else if (q.sp <= cur.ustart) begin
          n.st = ramp_pkg::ST_OFF; // see [RQ5]
        end else if (step) begin
          n.sp = q.sp - 14'h1; // see [RQ3] [RQ17]
        end
      end
    endcase
    if (n.st == ramp_pkg::ST_OFF) begin
      n.sp = 14'h0;
      n.on = 1'b0;
      ev[ramp_pkg::IRQ_OFF] = q.on;
    end
    ev[ramp_pkg::IRQ_CFG] = cfg_fail;
    // a new event wins over a clear in the same cycle
    n.irq_st = (q.irq_st & ~clr) | ev;
    n.irq = |(n.irq_st & n.irq_en);
    n.rdata = 32'h0;
    if (rd) begin
      unique case (addr)
        ramp_pkg::A_CTRL: n.rdata = {31'h0, q.use_fb};
        ramp_pkg::A_PAR_USTART: n.rdata = {18'h0, q.par.ustart};
        ramp_pkg::A_PAR_TRISE: n.rdata = {23'h0, q.par.trise};
        ramp_pkg::A_PAR_TFALL: n.rdata = {23'h0, q.par.tfall};
        ramp_pkg::A_STATUS: n.rdata = {26'h0, q.led, en_s, run_s, q.on, q.st};
        ramp_pkg::A_SETPOINT: n.rdata = {18'h0, q.sp};
        ramp_pkg::A_IRQ_STAT: n.rdata = {29'h0, q.irq_st};
        ramp_pkg::A_IRQ_EN: n.rdata = {29'h0, q.irq_en};
        default: n.rdata = 32'h0;
      endcase
    end
  end
  always_ff @(posedge clock) begin
    if (!resetn) begin
      q <= '{st: ramp_pkg::ST_OFF,
             par: '{ramp_pkg::RST_USTART, ramp_pkg::RST_TRISE, ramp_pkg::RST_TFALL},
             default: '0};
    end else begin
      q <= n;
    end
  end
  assign rdata = q.rdata;
  assign voltage_setpoint = q.sp;
  assign output_on = q.on;
  assign irq = q.irq;
  assign led_green = q.led;
  assign led_red = q.led;
  // ****************************************
  // checks
  // ****************************************
  a_rise_start_level: assert property (@(posedge clock) disable iff (!resetn) // see [RQ1]
    q.st == ramp_pkg::ST_OFF && run_rise && !cut |=> q.sp == $past(cur.ustart) && q.on)
    else $error("rise does not begin at start level");
  a_rise_monotonic: assert property (@(posedge clock) disable iff (!resetn) // see [RQ2]
    q.st == ramp_pkg::ST_RISE && n.st == ramp_pkg::ST_RISE |=> q.sp >= $past(q.sp))
    else $error("rising ramp went down");
  a_fall_monotonic: assert property (@(posedge clock) disable iff (!resetn) // see [RQ3]
    q.st == ramp_pkg::ST_FALL && n.st == ramp_pkg::ST_FALL |=> q.sp <= $past(q.sp))
    else $error("falling ramp went up");
  a_fall_on_drop: assert property (@(posedge clock) disable iff (!resetn) // see [RQ4]
    q.st == ramp_pkg::ST_FULL && run_fall && !cut && cur.tfall != 9'h0
    |=> q.st == ramp_pkg::ST_FALL) else $error("run removal did not start fall");
  a_off_at_floor: assert property (@(posedge clock) disable iff (!resetn) // see [RQ5]
    $fell(q.on) |-> q.sp == 14'h0 && q.st == ramp_pkg::ST_OFF)
    else $error("output off with voltage left");
  a_no_fall_zero: assert property (@(posedge clock) disable iff (!resetn) // see [RQ6]
    q.st != ramp_pkg::ST_OFF && run_fall && cur.tfall == 9'h0 && !run_rise
    |=> !q.on) else $error("zero fall time did not cut output");
  a_enable_cut: assert property (@(posedge clock) disable iff (!resetn) // see [RQ7]
    LARGE_UNIT && !en_s |=> !q.on) else $error("enable low left output on");
  a_abort_fall: assert property (@(posedge clock) disable iff (!resetn) // see [RQ8]
    q.st == ramp_pkg::ST_FALL && run_rise && !cut && !stop_ramp
    |=> q.st == ramp_pkg::ST_RISE && q.sp == $past(q.sp)) else $error("fall not aborted");
  a_bus_stop_now: assert property (@(posedge clock) disable iff (!resetn) // see [RQ10]
    stop_now |=> !q.on ##1 !q.on) else $error("fieldbus stop ignored");
  a_hold_full: assert property (@(posedge clock) disable iff (!resetn) // see [RQ18]
    q.st == ramp_pkg::ST_FULL |-> q.sp == ramp_pkg::V_FULL && q.on)
    else $error("full level not held");
endmodule : motor_voltage_ramp_control

// ===== verification/motor_load.sv
// behavioural three-phase motor load seen through the power stage
module motor_load (
  input wire logic clock, // system clock
  input wire logic [13:0] voltage_setpoint, // applied stator voltage
  input wire logic output_on, // power stage enabled
  output logic [15:0] speed, // shaft speed, arbitrary units
  output logic coasting // turning with no drive applied
);
  timeunit 1ns;
  timeprecision 1ps;
  initial speed = 16'h0000;
  // ****************************************
  // shaft model
  // ****************************************
  always @(posedge clock) begin
    if (output_on && ({2'h0, voltage_setpoint} > speed)) begin
      speed <= speed + 16'h0010;
    end else if (!output_on && speed != 16'h0000) begin
      // friction brakes a free-running shaft slowly
      speed <= speed - 16'h0001;
    end
  end
  assign coasting = !output_on && (speed != 16'h0000);
endmodule : motor_load

// ===== verification/tb.sv
// self-checking bench of the motor voltage ramp controller
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock = 1'b0;
  logic resetn = 1'b0;
  logic run = 1'b0;
  logic enable_in = 1'b0;
  logic [13:0] pot_ustart = 14'h3fc0;
  logic [8:0] pot_trise = 9'h00a;
  logic [8:0] pot_tfall = 9'h000;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [31:0] rdata;
  logic [13:0] sp;
  logic on;
  logic irq;
  logic led_g;
  logic led_r;
  logic [15:0] speed;
  logic [31:0] v;
  logic [13:0] mid;
  int error_cnt = 0;
  int num_checks = 0;
  int n;
  int hi;
  int bad;
  always #4 clock = ~clock;
  // large unit with fieldbus comes from the defaults; only the timebases are shortened
  motor_voltage_ramp_control #(.CYC_DS(8), .WIN_CYC(200),
    .FL_CYC(64), .HALF_CYC(4)) i_motor_voltage_ramp_control (.clock(clock), .resetn(resetn),
    .run_command_input(run), .enable_in(enable_in), .pot_ustart(pot_ustart),
    .pot_trise(pot_trise), .pot_tfall(pot_tfall), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .voltage_setpoint(sp), .output_on(on), .irq(irq),
    .led_green(led_g), .led_red(led_r));
  motor_load i_motor_load (.clock(clock), .voltage_setpoint(sp), .output_on(on),
    .speed(speed), .coasting());
  // ****************************************
  // shared tasks
  // ****************************************
  task conclude;
    if (error_cnt == 0 && num_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : conclude
  task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
      error_cnt++;
    end
  endtask : chk
  task tick(input int k);
    repeat (k) @(posedge clock);
  endtask : tick
  task do_reset;
    resetn <= 1'b0;
    tick(8);
    resetn <= 1'b1;
    tick(2);
  endtask : do_reset
  task wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clock);
    wr <= 1'b0;
  endtask : wr_reg
  task rd_reg(input logic [7:0] a);
    @(posedge clock);
    rd <= 1'b1;
    addr <= a;
    @(posedge clock);
    rd <= 1'b0;
    #1;
    v = rdata;
  endtask : rd_reg
  // counts cycles until setpoint or output_on shows the target
  task wait_until(input bit use_sp, input logic [13:0] t);
    n = 0;
    while (use_sp ? (sp !== t) : (on !== t[0])) begin
      tick(1);
      n++;
      if (n > 4000) begin
        chk("bounded wait", 32'h1, 32'h0);
        conclude();
      end
    end
  endtask : wait_until
  // ****************************************
  // scenarios
  // ****************************************
  task t_regs;
    rd_reg(ramp_pkg::A_PAR_USTART);
    chk("start voltage param", 32'h1333, v);
    rd_reg(ramp_pkg::A_PAR_TRISE);
    chk("rise time param", 32'h0032, v);
    rd_reg(ramp_pkg::A_PAR_TFALL);
    chk("fall time param", 32'h0000, v);
    wr_reg(8'h30, 32'hffff_ffff);
    rd_reg(8'h30);
    chk("unmapped read", 32'h0, v);
    chk("output off after reset", 1'b0, on);
  endtask : t_regs
  task t_rise;
    wr_reg(ramp_pkg::A_IRQ_EN, 32'h0);
    enable_in <= 1'b1;
    tick(2);
    run <= 1'b1;
    wait_until(1'b0, 14'h0001);
    chk("ramp start level", 14'h3fc0, sp);
    wait_until(1'b1, 14'h3fff);
    chk("rise in time", 1'b1, n >= 76 && n <= 84);
    tick(30);
    chk("hold full", 14'h3fff, sp);
    chk("masked irq", 1'b0, irq);
    rd_reg(ramp_pkg::A_IRQ_STAT);
    chk("rise done flag", 1'b1, v[0]);
    wr_reg(ramp_pkg::A_IRQ_EN, 32'h1);
    tick(1);
    chk("irq raised", 1'b1, irq);
    wr_reg(ramp_pkg::A_IRQ_CLR, 32'h1);
    tick(1);
    chk("irq cleared", 1'b0, irq);
    wr_reg(ramp_pkg::A_IRQ_EN, 32'h0);
  endtask : t_rise
  task t_stop_zero;
    run <= 1'b0;
    wait_until(1'b0, 14'h0000);
    chk("immediate off", 1'b1, n <= 6);
    chk("setpoint after off", 14'h0000, sp);
  endtask : t_stop_zero
  task t_stop_ramp;
    pot_tfall <= 9'h00a;
    run <= 1'b1;
    wait_until(1'b1, 14'h3fff);
    run <= 1'b0;
    tick(40);
    chk("falling midway", 1'b1, on && sp > 14'h3fc0 && sp < 14'h3fff);
    wait_until(1'b0, 14'h0000);
    chk("fall in time", 1'b1, n >= 38 && n <= 52);
    chk("setpoint after fall", 14'h0000, sp);
  endtask : t_stop_ramp
  task t_abort;
    run <= 1'b1;
    wait_until(1'b1, 14'h3fff);
    run <= 1'b0;
    tick(43);
    mid = sp;
    run <= 1'b1;
    tick(5);
    chk("rise from present", 1'b1, on && sp > mid - 14'h0008);
    wait_until(1'b1, 14'h3fff);
    chk("short rise", 1'b1, n < 60);
    pot_tfall <= 9'h000;
    run <= 1'b0;
    wait_until(1'b0, 14'h0000);
  endtask : t_abort
  task t_enable;
    pot_ustart <= 14'h0100;
    run <= 1'b1;
    wait_until(1'b0, 14'h0001);
    chk("clamped start level", ramp_pkg::V_MIN, sp);
    tick(20);
    enable_in <= 1'b0;
    wait_until(1'b0, 14'h0000);
    chk("enable cut", 1'b1, n <= 6);
    run <= 1'b0;
    tick(4);
    run <= 1'b1;
    tick(10);
    chk("run refused without enable", 1'b0, on);
    run <= 1'b0;
    pot_ustart <= 14'h3fc0;
    enable_in <= 1'b1;
    tick(4);
  endtask : t_enable
  task t_fieldbus;
    wr_reg(ramp_pkg::A_CTRL, 32'h1);
    wr_reg(ramp_pkg::A_PAR_USTART, 32'h3fd0);
    wr_reg(ramp_pkg::A_PAR_TRISE, 32'h000a);
    wr_reg(ramp_pkg::A_PAR_TFALL, 32'h000a);
    run <= 1'b1;
    wait_until(1'b0, 14'h0001);
    chk("fieldbus start level", 14'h3fd0, sp);
    wait_until(1'b1, 14'h3fff);
    wr_reg(ramp_pkg::A_CMD, 32'h1);
    wait_until(1'b0, 14'h0000);
    chk("fieldbus ramped stop", 1'b1, n >= 70 && n <= 88);
    run <= 1'b0;
    tick(4);
    run <= 1'b1;
    wait_until(1'b0, 14'h0001);
    wr_reg(ramp_pkg::A_CMD, 32'h2);
    wait_until(1'b0, 14'h0000);
    chk("fieldbus immediate stop", 1'b1, n <= 3);
    run <= 1'b0;
    wr_reg(ramp_pkg::A_CTRL, 32'h0);
  endtask : t_fieldbus
  task t_config;
    pot_ustart <= 14'h3fff;
    pot_trise <= 9'h12c;
    do_reset();
    pot_ustart <= 14'h1333;
    pot_trise <= 9'h00a;
    wait_until(1'b0, 14'h0000);
    n = 0;
    while (led_g !== 1'b1 && n < 30) begin
      tick(1);
      n++;
    end
    hi = 0;
    bad = 0;
    repeat (80) begin
      tick(1);
      hi += int'(led_g === 1'b1);
      bad += int'(led_g !== led_r);
    end
    chk("flash length", 1'b1, hi >= 28 && hi <= 36);
    chk("indicators differ", 32'h0, bad);
    chk("flash ended", 1'b0, led_g);
    rd_reg(ramp_pkg::A_IRQ_STAT);
    chk("config fail flag", 1'b1, v[2]);
    pot_ustart <= 14'h3fff;
    pot_trise <= 9'h12c;
    do_reset();
    pot_trise <= 9'h00a;
    tick(150);
    chk("no early fail", 1'b0, led_g);
    n = 0;
    while (led_g !== 1'b1 && n < 100) begin
      tick(1);
      n++;
    end
    chk("window fail", 1'b1, n >= 40 && n <= 60);
    tick(70);
  endtask : t_config
  initial begin
    do_reset();
    t_regs();
    t_rise();
    t_stop_zero();
    t_stop_ramp();
    t_abort();
    t_enable();
    t_fieldbus();
    t_config();
    conclude();
  end
endmodule : tb
